// ---- dv/dtg_debug_trigger_gate_chk.sv ----
// Checker for the debug trigger gate register bank
`timescale 1ns/1ps
module dtg_debug_trigger_gate_chk import dtg_pkg::*; #(
	parameter logic [31:0] COMPONENT_ID = DTG_COMPONENT_ID_DEF // Arbitrary value
) (
	input logic clk,
	input logic reset_n,
	input logic [11:0] reg_addr,
	input logic [31:0] reg_wdata,
	input logic reg_write,
	input logic reg_read,
	input logic [31:0] reg_rdata,
	input logic invasive_debug_enable,
	input logic noninvasive_debug_enable,
	input logic [7:0] cross_trigger_input_lines,
	input logic [7:0] cross_trigger_inputs,
	input logic [3:0] trig_out_request,
	input logic [3:0] cross_trigger_outputs,
	input logic [3:0] cross_trigger_output_ack,
	input logic pll_locked,
	input logic main_clock_ready
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic [27:0] cfg_ff; // Shadow of the config register
	logic [7:0] ipass; // Inputs let through
	logic [3:0] opass; // Outputs let through
	// Shadow follows writes only, so it never trusts the design
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) cfg_ff <= 28'h0;
		else if (reg_write && reg_addr == DTG_OFF_STATIC_CONFIG) cfg_ff <= reg_wdata[27:0];
	end
	assign ipass = cfg_ff[23:16] | {8{noninvasive_debug_enable}};
	assign opass = cfg_ff[27:24] | {4{invasive_debug_enable}};
	property p_id;
		reg_read && reg_addr == DTG_OFF_COMPONENT_ID |=> reg_rdata == COMPONENT_ID;
	endproperty
	a_id: assert property (p_id) else $error("id read wrong");
	property p_stat;
		reg_read && reg_addr == DTG_OFF_CLOCK_FLAGS && $past(reset_n) && $stable(pll_locked)
			&& $stable(main_clock_ready) |=> reg_rdata ==
			{29'h0, $past(pll_locked), 1'h0, $past(main_clock_ready)};
	endproperty
	a_stat: assert property (p_stat) else $error("status read wrong");
	property p_cfg;
		reg_read && reg_addr == DTG_OFF_STATIC_CONFIG |=> reg_rdata == {4'h0, $past(cfg_ff)};
	endproperty
	a_cfg: assert property (p_cfg) else $error("config read wrong");
	property p_in_byp;
		((cross_trigger_inputs ^ $past(cross_trigger_input_lines & ipass))
			& $past(cfg_ff[7:0])) == 8'h00;
	endproperty
	a_in_byp: assert property (p_in_byp) else $error("bypass input wrong");
	property p_in_sync;
		((cross_trigger_inputs ^ ($past(cross_trigger_input_lines, 3) & $past(ipass)))
			& ~$past(cfg_ff[7:0])) == 8'h00;
	endproperty
	a_in_sync: assert property (p_in_sync) else $error("synced input wrong");
	property p_in_mask;
		(cross_trigger_inputs & ~$past(ipass)) == 8'h00;
	endproperty
	a_in_mask: assert property (p_in_mask) else $error("input not masked");
	property p_out_byp;
		((cross_trigger_outputs ^ $past(trig_out_request & opass)) & $past(cfg_ff[15:12])) == 4'h0;
	endproperty
	a_out_byp: assert property (p_out_byp) else $error("bypass output wrong");
	property p_out_rise;
		(cross_trigger_outputs & ~$past(cross_trigger_outputs)
			& ~$past(trig_out_request & opass)) == 4'h0;
	endproperty
	a_out_rise: assert property (p_out_rise) else $error("output rose masked");
	property p_ack_byp;
		(cross_trigger_outputs & $past(cross_trigger_outputs & cross_trigger_output_ack
			& cfg_ff[11:8] & ~cfg_ff[15:12])) == 4'h0;
	endproperty
	a_ack_byp: assert property (p_ack_byp) else $error("raw ack ignored");
	c_id: cover property (reg_read && reg_addr == DTG_OFF_COMPONENT_ID);
	c_ack: cover property ((cross_trigger_outputs & cross_trigger_output_ack) != 4'h0);
	c_in: cover property (cross_trigger_inputs != 8'h00);
endmodule // dtg_debug_trigger_gate_chk

// ---- dv/test_dtg_debug_trigger_gate.sv ----
// Self-checking testbench for the debug trigger gate register bank
`timescale 1ns/1ps
module test_dtg_debug_trigger_gate import dtg_pkg::*;;
	logic clk = 1'h0, reset_n = 1'h0, reg_write = 1'h0, reg_read = 1'h0;
	logic invasive_debug_enable = 1'h0, noninvasive_debug_enable = 1'h0;
	logic pll_locked = 1'h1, main_clock_ready = 1'h1; // Sources start high; t_regs and t_rst drive them low
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [7:0] cross_trigger_input_lines = 8'h00, cross_trigger_inputs;
	logic [3:0] trig_out_request = 4'h0, cross_trigger_output_ack = 4'h0;
	logic [3:0] cross_trigger_outputs;
	int error_cnt = 0, n_tests = 0, cyc = 0; // Counters
	dtg_debug_trigger_gate dtg_debug_trigger_gate_i (.*);
	// Clock, 10 ns period
	initial forever #5 clk = ~clk;
	// Hang guard, far beyond the fewer than a hundred cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			end_of_test();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One-cycle write strobe
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'h1;
		@(posedge clk);
		reg_write <= 1'h0;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'h1;
		@(posedge clk);
		reg_read <= 1'h0;
		#1 chk(reg_rdata, e);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic t_regs();
		rd(DTG_OFF_STATIC_CONFIG, 32'h0);
		rd(DTG_OFF_COMPONENT_ID, DTG_COMPONENT_ID_DEF);
		rd(DTG_OFF_CLOCK_FLAGS, 32'h5);
		rd(12'h00C, 32'h0);
		wr(DTG_OFF_STATIC_CONFIG, 32'hFFFF_FFFF);
		rd(DTG_OFF_STATIC_CONFIG, 32'h0FFF_FFFF);
		wr(DTG_OFF_COMPONENT_ID, 32'h0);
		wr(DTG_OFF_CLOCK_FLAGS, 32'h0);
		rd(DTG_OFF_COMPONENT_ID, DTG_COMPONENT_ID_DEF);
		// A write of zeros must not have cleared either flag
		rd(DTG_OFF_CLOCK_FLAGS, 32'h5);
		@(posedge clk) pll_locked <= 1'h0;
		rd(DTG_OFF_CLOCK_FLAGS, 32'h1);
		@(posedge clk) {pll_locked, main_clock_ready} <= 2'h2;
		rd(DTG_OFF_CLOCK_FLAGS, 32'h4);
		$display("register test done");
	endtask
	// Lines come from this clock, so bypass is legal
	task automatic t_in();
		wr(DTG_OFF_STATIC_CONFIG, 32'h0055_00FF);
		@(posedge clk) cross_trigger_input_lines <= 8'hFF;
		tick(1);
		chk(32'(cross_trigger_inputs), 32'h55);
		@(posedge clk) noninvasive_debug_enable <= 1'h1;
		tick(1);
		chk(32'(cross_trigger_inputs), 32'hFF);
		@(posedge clk) cross_trigger_input_lines <= 8'h00;
		wr(DTG_OFF_STATIC_CONFIG, 32'h0000_000F);
		@(posedge clk) cross_trigger_input_lines <= 8'h81;
		tick(1);
		chk(32'(cross_trigger_inputs), 32'h01);
		tick(2);
		chk(32'(cross_trigger_inputs), 32'h81);
		$display("input test done");
	endtask
	task automatic t_out();
		wr(DTG_OFF_STATIC_CONFIG, 32'h0300_F000);
		@(posedge clk) trig_out_request <= 4'hF;
		tick(1);
		chk(32'(cross_trigger_outputs), 32'h3);
		@(posedge clk) invasive_debug_enable <= 1'h1;
		tick(1);
		chk(32'(cross_trigger_outputs), 32'hF);
		@(posedge clk) trig_out_request <= 4'h0;
		wr(DTG_OFF_STATIC_CONFIG, 32'h0000_0C00);
		@(posedge clk) trig_out_request <= 4'hF;
		tick(1);
		chk(32'(cross_trigger_outputs), 32'hF);
		@(posedge clk) cross_trigger_output_ack <= 4'hF;
		tick(1);
		chk(32'(cross_trigger_outputs), 32'h3);
		tick(2);
		chk(32'(cross_trigger_outputs), 32'h0);
		tick(1);
		chk(32'(cross_trigger_outputs), 32'h0);
		$display("output test done");
	endtask
	// Mid-run reset; a read taken at the first edge after release
	// still sees both flags at their reset value although the sources are low
	task automatic t_rst();
		@(posedge clk) begin
			noninvasive_debug_enable <= 1'h0;
			{pll_locked, main_clock_ready} <= 2'h0;
		end
		wr(DTG_OFF_STATIC_CONFIG, 32'h0FFF_FFFF);
		@(posedge clk) reset_n <= 1'h0;
		tick(1);
		chk(32'(cross_trigger_outputs), 32'h0);
		chk(32'(cross_trigger_inputs), 32'h0);
		repeat (2) @(posedge clk);
		reset_n <= 1'h1;
		reg_addr <= DTG_OFF_CLOCK_FLAGS;
		reg_read <= 1'h1;
		@(posedge clk);
		reg_read <= 1'h0;
		#1 chk(reg_rdata, 32'h5);
		rd(DTG_OFF_CLOCK_FLAGS, 32'h0);
		rd(DTG_OFF_STATIC_CONFIG, 32'h0);
		$display("reset test done");
	endtask
	initial begin
		repeat (6) @(posedge clk);
		reset_n <= 1'h1;
		t_regs();
		t_in();
		t_out();
		t_rst();
		end_of_test();
	end
endmodule // test_dtg_debug_trigger_gate
bind dtg_debug_trigger_gate dtg_debug_trigger_gate_chk #(.COMPONENT_ID(COMPONENT_ID))
	dtg_debug_trigger_gate_chk_i (.*);

// ---- verilog/dtg_debug_trigger_gate.sv ----
// Debug trigger gate, trigger synchroniser bypass and clock status register bank
`timescale 1ns/1ps

module dtg_debug_trigger_gate
	import dtg_pkg::*;
#(
	parameter logic [31:0] COMPONENT_ID = DTG_COMPONENT_ID_DEF // Arbitrary value
) (
	input wire logic clk,
	input wire logic reset_n,
	// Register port
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	// Authentication levels
	input wire logic invasive_debug_enable,
	input wire logic noninvasive_debug_enable,
	// Trigger inputs from the outside world, possibly asynchronous
	input wire logic [7:0] cross_trigger_input_lines,
	// Gated trigger inputs towards the trigger matrix
	output logic [7:0] cross_trigger_inputs,
	// Trigger output requests from the trigger matrix
	input wire logic [3:0] trig_out_request,
	// Gated trigger outputs and their acknowledges
	output logic [3:0] cross_trigger_outputs,
	input wire logic [3:0] cross_trigger_output_ack,
	// Clock state sources
	input wire logic pll_locked,
	input wire logic main_clock_ready
);

	// Configuration fields
	logic [3:0] out_mask_ff; // trig_out_debug_mask_sel
	logic [7:0] in_mask_ff; // trig_in_noninvasive_mask_sel
	logic [3:0] hs_byp_ff; // trig_handshake_bypass
	logic [3:0] ack_byp_ff; // ack_sync_bypass
	logic [7:0] in_byp_ff; // trig_in_sync_bypass
	logic [3:0] nxt_out_mask;
	logic [7:0] nxt_in_mask;
	logic [3:0] nxt_hs_byp;
	logic [3:0] nxt_ack_byp;
	logic [7:0] nxt_in_byp;

	// Clock status flags
	logic pll_lock_ff;
	logic main_rdy_ff;
	logic nxt_pll_lock;
	logic nxt_main_rdy;

	// Read data
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [31:0] config_word; // Assembled configuration value

	// Trigger paths
	logic [7:0] in_sync; // Synchronised trigger inputs
	logic [3:0] ack_sync; // Synchronised acknowledges
	logic [7:0] in_sel; // After bypass choice
	logic [3:0] ack_sel; // After bypass choice
	logic [7:0] in_gate_ff; // Registered gated inputs
	logic [7:0] nxt_in_gate;
	logic [3:0] out_ff; // Registered trigger outputs
	logic [3:0] nxt_out;
	logic [3:0] req_gated; // Requests after debug masking

	// Synchroniser for the trigger input lines
	dtg_sync_bank #(
		.WIDTH(DTG_IN_CH)
	) u_in_sync (
		.clk(clk),
		.reset_n(reset_n),
		.async_in(cross_trigger_input_lines),
		.sync_out(in_sync)
	);

	// Synchroniser for the output acknowledges
	dtg_sync_bank #(
		.WIDTH(DTG_OUT_CH)
	) u_ack_sync (
		.clk(clk),
		.reset_n(reset_n),
		.async_in(cross_trigger_output_ack),
		.sync_out(ack_sync)
	);

	// Configuration next values; writes only touch defined fields
	always_comb begin
		nxt_out_mask = out_mask_ff;
		nxt_in_mask = in_mask_ff;
		nxt_hs_byp = hs_byp_ff;
		nxt_ack_byp = ack_byp_ff;
		nxt_in_byp = in_byp_ff;
		if (reg_write && reg_addr == DTG_OFF_STATIC_CONFIG) begin
			// Bits 31 to 28 are dropped here
			nxt_out_mask = reg_wdata[DTG_OUT_MASK_LSB +: 4];
			nxt_in_mask = reg_wdata[DTG_IN_MASK_LSB +: 8];
			nxt_hs_byp = reg_wdata[DTG_HS_BYP_LSB +: 4];
			nxt_ack_byp = reg_wdata[DTG_ACK_BYP_LSB +: 4];
			nxt_in_byp = reg_wdata[DTG_IN_BYP_LSB +: 8];
		end
	end

	// Configuration registers, all fields clear at reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			out_mask_ff <= DTG_RST_OUT_MASK;
			in_mask_ff <= DTG_RST_IN_MASK;
			hs_byp_ff <= DTG_RST_HS_BYP;
			ack_byp_ff <= DTG_RST_ACK_BYP;
			in_byp_ff <= DTG_RST_IN_BYP;
		end else begin
			out_mask_ff <= nxt_out_mask;
			in_mask_ff <= nxt_in_mask;
			hs_byp_ff <= nxt_hs_byp;
			ack_byp_ff <= nxt_ack_byp;
			in_byp_ff <= nxt_in_byp;
		end
	end

	// Clock flags follow their sources; writes have no path here
	always_comb begin
		nxt_pll_lock = pll_locked;
		nxt_main_rdy = main_clock_ready;
	end

	// Clock flags load 1 while reset holds
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pll_lock_ff <= DTG_RST_PLL_LOCK;
			main_rdy_ff <= DTG_RST_MAIN_RDY;
		end else begin
			pll_lock_ff <= nxt_pll_lock;
			main_rdy_ff <= nxt_main_rdy;
		end
	end

	// Per-channel bypass choice and gating, one generate per direction
	// Bypass cuts two cycles of latency but is only safe for same-domain sources
	genvar gi;
	generate
		for (gi = 0; gi < DTG_IN_CH; gi++) begin : g_in
			// Raw line when bypassed, synchronised copy otherwise
			assign in_sel[gi] = in_byp_ff[gi] ? cross_trigger_input_lines[gi] :
				in_sync[gi];
		end
		for (gi = 0; gi < DTG_OUT_CH; gi++) begin : g_out
			// Acknowledge path choice per output channel
			assign ack_sel[gi] = ack_byp_ff[gi] ? cross_trigger_output_ack[gi] :
				ack_sync[gi];
			// Request passes when unmasked or while debug is enabled
			assign req_gated[gi] = trig_out_request[gi] &
				(out_mask_ff[gi] | invasive_debug_enable);
		end
	endgenerate

	// Input gating: noninvasive enable or the channel mask lets it through
	always_comb begin
		nxt_in_gate = in_sel & (in_mask_ff | {DTG_IN_CH{noninvasive_debug_enable}});
	end

	// Output next state, handshake or direct
	// With the handshake, a raised output holds until acknowledged, then a new
	// request is taken only after the acknowledge falls again
	always_comb begin
		nxt_out = out_ff;
		for (int i = 0; i < DTG_OUT_CH; i++) begin
			if (hs_byp_ff[i]) begin
				// Handshake off: output follows the gated request
				nxt_out[i] = req_gated[i];
			end else if (out_ff[i]) begin
				// Waiting for acknowledge
				nxt_out[i] = ~ack_sel[i];
			end else begin
				// Idle: raise on request once acknowledge is low
				nxt_out[i] = req_gated[i] & ~ack_sel[i];
			end
		end
	end

	// Trigger path registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			in_gate_ff <= '0;
			out_ff <= '0;
		end else begin
			in_gate_ff <= nxt_in_gate;
			out_ff <= nxt_out;
		end
	end

	assign cross_trigger_inputs = in_gate_ff;
	assign cross_trigger_outputs = out_ff;

	// Configuration word with reserved top nibble at zero
	always_comb begin
		config_word = '0;
		config_word[DTG_OUT_MASK_LSB +: 4] = out_mask_ff;
		config_word[DTG_IN_MASK_LSB +: 8] = in_mask_ff;
		config_word[DTG_HS_BYP_LSB +: 4] = hs_byp_ff;
		config_word[DTG_ACK_BYP_LSB +: 4] = ack_byp_ff;
		config_word[DTG_IN_BYP_LSB +: 8] = in_byp_ff;
	end

	// Read mux; unmapped offsets and idle cycles give zero
	always_comb begin
		nxt_rdata = '0;
		if (reg_read) begin
			case (reg_addr)
				DTG_OFF_STATIC_CONFIG: begin
					nxt_rdata = config_word;
				end
				DTG_OFF_COMPONENT_ID: begin
					// Constant, no write path exists
					nxt_rdata = COMPONENT_ID;
				end
				DTG_OFF_CLOCK_FLAGS: begin
					// Bits 31 to 3 and bit 1 stay zero
					nxt_rdata[DTG_PLL_LOCK_BIT] = pll_lock_ff;
					nxt_rdata[DTG_MAIN_RDY_BIT] = main_rdy_ff;
				end
				default: begin
					nxt_rdata = '0;
				end
			endcase
		end
	end

	// Read data register, valid the cycle after the strobe
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;

endmodule // dtg_debug_trigger_gate

// ---- verilog/dtg_pkg.sv ----
// Package with offsets, field layouts and reset values of the debug trigger gate bank
package dtg_pkg;

	// Widths
	localparam int DTG_DATA_W = 32;
	localparam int DTG_ADDR_W = 12;
	localparam int DTG_OUT_CH = 4;
	localparam int DTG_IN_CH = 8;

	// Register byte offsets
	localparam logic [11:0] DTG_OFF_STATIC_CONFIG = 12'h000;
	localparam logic [11:0] DTG_OFF_COMPONENT_ID = 12'h004;
	localparam logic [11:0] DTG_OFF_CLOCK_FLAGS = 12'h008;

	// Field positions in debug_trigger_static_config
	localparam int DTG_OUT_MASK_LSB = 24;
	localparam int DTG_IN_MASK_LSB = 16;
	localparam int DTG_HS_BYP_LSB = 12;
	localparam int DTG_ACK_BYP_LSB = 8;
	localparam int DTG_IN_BYP_LSB = 0;

	// Field positions in clock_state_flags
	localparam int DTG_PLL_LOCK_BIT = 2;
	localparam int DTG_MAIN_RDY_BIT = 0;

	// Reset values
	localparam logic [3:0] DTG_RST_OUT_MASK = 4'h0;
	localparam logic [7:0] DTG_RST_IN_MASK = 8'h00;
	localparam logic [3:0] DTG_RST_HS_BYP = 4'h0;
	localparam logic [3:0] DTG_RST_ACK_BYP = 4'h0;
	localparam logic [7:0] DTG_RST_IN_BYP = 8'h00;
	localparam logic DTG_RST_PLL_LOCK = 1'b1;
	localparam logic DTG_RST_MAIN_RDY = 1'b1;

	// Identification value, arbitrary neutral value
	localparam logic [31:0] DTG_COMPONENT_ID_DEF = 32'h0000_A5C3;

endpackage

// ---- verilog/dtg_sync_bank.sv ----
// Bank of two-flop level synchronisers
`timescale 1ns/1ps

module dtg_sync_bank #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_ff; // First stage, read only by the second stage
	logic [WIDTH-1:0] sync_ff; // Second stage, safe to use
	logic [WIDTH-1:0] nxt_meta;
	logic [WIDTH-1:0] nxt_sync;

	// Next values of both stages
	always_comb begin
		nxt_meta = async_in;
		nxt_sync = meta_ff;
	end

	// Stage registers, cleared at reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign sync_out = sync_ff;

endmodule // dtg_sync_bank
